// file: csd_pkg.sv
// constants and carrier types for the control mode strap decoder
package csd_pkg;

    // strap pin positions within the level and float vectors
    localparam int PIN_SWING = 0;
    localparam int PIN_EDGE  = 1;
    localparam int PIN_DELAY = 2;
    localparam int PIN_MODE  = 3;
    localparam int PIN_COUNT = 4;

    // serial frame: address first, then data, msb first
    localparam int ADDR_BITS  = 4;
    localparam int DATA_BITS  = 16;
    localparam int FRAME_BITS = ADDR_BITS + DATA_BITS;
    localparam logic [4:0] FRAME_LAST = 5'h13;

    // user register slots and their serial addresses
    localparam int REG_COUNT = 8;
    localparam logic [7:0][3:0] SLOT_ADDR = {4'hE, 4'hD, 4'hB, 4'hA, 4'h9, 4'h3, 4'h2, 4'h1};
    localparam logic [2:0] SLOT_CONFIG = 3'h0;
    localparam logic [2:0] SLOT_INTLV  = 3'h6;
    localparam logic [7:0] ALL_WRITTEN = 8'hFF;

    // reset values
    localparam logic [15:0] INTLV_RESET   = 16'h3FFF;
    localparam logic [15:0] DEFAULT_RESET = 16'h0000;

    // field positions in the config and interleave registers
    localparam int CFG_FS_BIT    = 9;
    localparam int CFG_DDR_BIT   = 10;
    localparam int CFG_CAL_BIT   = 11;
    localparam int CFG_EDGE_BIT  = 12;
    localparam int CFG_SWING_BIT = 13;
    localparam int INTLV_EN_BIT  = 15;

    typedef struct packed {
        logic [PIN_COUNT-1:0] float_det;
        logic [PIN_COUNT-1:0] level;
    } csd_strap_t;

    typedef struct packed {
        logic extended;
        logic swing_normal;
        logic edge_pos;
        logic ddr;
        logic cal_long;
        logic fullscale_normal;
        logic interleave;
    } csd_settings_t;

    localparam csd_settings_t SETTINGS_RESET = '{default: 1'b0};

endpackage : csd_pkg

// file: csd_sync3.sv
// three-stage synchroniser whose output moves once stages two and three agree
`timescale 1ns/1ns
module csd_sync3 #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] filt_out
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;
    logic [WIDTH-1:0] stage3_reg;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    stage1_reg[i] <= 1'b0;
                    stage2_reg[i] <= 1'b0;
                    stage3_reg[i] <= 1'b0;
                    filt_out[i]   <= 1'b0;
                end else begin
                    stage1_reg[i] <= async_in[i];
                    stage2_reg[i] <= stage1_reg[i];
                    stage3_reg[i] <= stage2_reg[i];
                    // a lone glitch in stage two never reaches the output
                    if (stage2_reg[i] == stage3_reg[i]) begin
                        filt_out[i] <= stage3_reg[i];
                    end
                end
            end
        end
    endgenerate

endmodule : csd_sync3

// file: csd_strap_decoder.sv
// strap decoder with serial register interface for extended mode
`timescale 1ns/1ns
module csd_strap_decoder (
    input  wire logic                     clk_sys,
    input  wire logic                     reset_n,
    input  wire csd_pkg::csd_strap_t      strap_pins,
    input  wire logic                     serial_clk,
    input  wire logic                     serial_shift_data,
    input  wire logic                     serial_select_n,
    output csd_pkg::csd_settings_t        settings_reg,
    output logic [csd_pkg::REG_COUNT-1:0] written_mask_reg,
    output logic                          config_complete_reg,
    output logic                          intlv_order_err_reg
);

    // slot lookup: bit 3 flags a hit, bits 2:0 give the slot
    function automatic logic [3:0] addr_slot(input logic [csd_pkg::ADDR_BITS-1:0] addr);
        logic [3:0] res;
        res = 4'h0;
        for (int s = 0; s < csd_pkg::REG_COUNT; s++) begin
            if (csd_pkg::SLOT_ADDR[s] == addr) begin
                res = {1'b1, 3'(s)};
            end
        end
        return res;
    endfunction : addr_slot

    // ---------------- link domain ----------------
    logic [4:0]                       bit_cnt_reg;
    logic [csd_pkg::FRAME_BITS-2:0]   shift_reg;
    logic [csd_pkg::FRAME_BITS-1:0]   word_hold_reg;
    logic                             word_tog_reg;

    // frame ends with select high, which clears the bit count at once
    always_ff @(posedge serial_clk or posedge serial_select_n or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt_reg <= 5'h00;
            shift_reg   <= '0;
        end else if (serial_select_n) begin
            bit_cnt_reg <= 5'h00;
            shift_reg   <= '0;
        end else begin
            shift_reg <= {shift_reg[csd_pkg::FRAME_BITS-3:0], serial_shift_data};
            if (bit_cnt_reg == csd_pkg::FRAME_LAST) begin
                bit_cnt_reg <= 5'h00;
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
        end
    end

    // word is held until the next frame completes, long after the sys side took it
    always_ff @(posedge serial_clk or negedge reset_n) begin
        if (!reset_n) begin
            word_hold_reg <= '0;
            word_tog_reg  <= 1'b0;
        end else if (!serial_select_n && bit_cnt_reg == csd_pkg::FRAME_LAST) begin
            word_hold_reg <= {shift_reg, serial_shift_data};
            word_tog_reg  <= ~word_tog_reg;
        end
    end

    // ---------------- system domain ----------------
    logic [2*csd_pkg::PIN_COUNT-1:0] strap_vec;
    csd_pkg::csd_strap_t             strap_f;
    logic                            tog_f;
    logic                            tog_seen_reg;
    logic                            word_evt;
    logic                            ext_now;
    logic [csd_pkg::ADDR_BITS-1:0]   wr_addr;
    logic [csd_pkg::DATA_BITS-1:0]   wr_data;
    logic [3:0]                      wr_hit;
    logic                            wr_ok;

    logic [csd_pkg::REG_COUNT-1:0][csd_pkg::DATA_BITS-1:0] regs_reg;
    csd_pkg::csd_settings_t                                settings_next;

    csd_sync3 #(
        .WIDTH (2*csd_pkg::PIN_COUNT)
    ) u_strap_sync (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .async_in (strap_pins),
        .filt_out (strap_vec)
    );

    csd_sync3 #(
        .WIDTH (1)
    ) u_tog_sync (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .async_in (word_tog_reg),
        .filt_out (tog_f)
    );

    assign strap_f  = csd_pkg::csd_strap_t'(strap_vec);
    assign ext_now  = strap_f.float_det[csd_pkg::PIN_MODE];
    assign word_evt = tog_f != tog_seen_reg;
    assign wr_addr  = word_hold_reg[csd_pkg::FRAME_BITS-1:csd_pkg::DATA_BITS];
    assign wr_data  = word_hold_reg[csd_pkg::DATA_BITS-1:0];
    assign wr_hit   = addr_slot(wr_addr);
    // frames are dropped outright in pin-strapped mode
    assign wr_ok    = word_evt && ext_now && wr_hit[3];

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tog_seen_reg <= 1'b0;
        end else begin
            tog_seen_reg <= tog_f;
        end
    end

    // user registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int s = 0; s < csd_pkg::REG_COUNT; s++) begin
                regs_reg[s] <= (3'(s) == csd_pkg::SLOT_INTLV) ? csd_pkg::INTLV_RESET
                                                                 : csd_pkg::DEFAULT_RESET;
            end
        end else if (wr_ok) begin
            regs_reg[wr_hit[2:0]] <= wr_data;
        end
    end

    // first-write tracking; leaving extended mode starts the sequence over
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            written_mask_reg <= '0;
        end else if (!ext_now) begin
            written_mask_reg <= '0;
        end else if (wr_ok) begin
            written_mask_reg[wr_hit[2:0]] <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            config_complete_reg <= 1'b0;
        end else begin
            config_complete_reg <= ext_now && (written_mask_reg == csd_pkg::ALL_WRITTEN);
        end
    end

    // sticky flag; a new violation wins over the mode-exit clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            intlv_order_err_reg <= 1'b0;
        end else if (wr_ok && wr_hit[2:0] == csd_pkg::SLOT_INTLV
                     && !written_mask_reg[csd_pkg::SLOT_INTLV]
                     && wr_data != csd_pkg::INTLV_RESET) begin
            intlv_order_err_reg <= 1'b1;
        end else if (!ext_now) begin
            intlv_order_err_reg <= 1'b0;
        end
    end

    // settings decode
    always_comb begin
        settings_next = csd_pkg::SETTINGS_RESET;
        if (ext_now) begin
            settings_next.extended         = 1'b1;
            settings_next.swing_normal     = regs_reg[csd_pkg::SLOT_CONFIG][csd_pkg::CFG_SWING_BIT];
            settings_next.ddr              = regs_reg[csd_pkg::SLOT_CONFIG][csd_pkg::CFG_DDR_BIT];
            settings_next.edge_pos         = !settings_next.ddr
                                             && regs_reg[csd_pkg::SLOT_CONFIG][csd_pkg::CFG_EDGE_BIT];
            settings_next.cal_long         = regs_reg[csd_pkg::SLOT_CONFIG][csd_pkg::CFG_CAL_BIT];
            settings_next.fullscale_normal = regs_reg[csd_pkg::SLOT_CONFIG][csd_pkg::CFG_FS_BIT];
            // held off until every register has had its first write
            settings_next.interleave       = config_complete_reg
                                             && regs_reg[csd_pkg::SLOT_INTLV][csd_pkg::INTLV_EN_BIT];
        end else begin
            settings_next.extended         = 1'b0;
            settings_next.fullscale_normal = strap_f.level[csd_pkg::PIN_MODE];
            settings_next.swing_normal     = strap_f.level[csd_pkg::PIN_SWING];
            settings_next.ddr              = strap_f.float_det[csd_pkg::PIN_EDGE];
            settings_next.edge_pos         = !strap_f.float_det[csd_pkg::PIN_EDGE]
                                             && strap_f.level[csd_pkg::PIN_EDGE];
            settings_next.interleave       = strap_f.float_det[csd_pkg::PIN_DELAY];
            // a floating delay pin gives no wait choice; short wait assumed
            settings_next.cal_long         = !strap_f.float_det[csd_pkg::PIN_DELAY]
                                             && strap_f.level[csd_pkg::PIN_DELAY];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            settings_reg <= csd_pkg::SETTINGS_RESET;
        end else begin
            settings_reg <= settings_next;
        end
    end

    // ---------------- assertions ----------------
    ext_mode_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        strap_f.float_det[csd_pkg::PIN_MODE] |=> settings_reg.extended
    ) else $error("floating mode pin did not give extended mode");

    strap_mode_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !strap_f.float_det[csd_pkg::PIN_MODE] |=> !settings_reg.extended
    ) else $error("driven mode pin did not give pin-strapped mode");

    fullscale_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !strap_f.float_det[csd_pkg::PIN_MODE]
        |=> settings_reg.fullscale_normal == $past(strap_f.level[csd_pkg::PIN_MODE])
    ) else $error("full-scale range does not follow mode pin level");

    swing_sel_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !ext_now |=> settings_reg.swing_normal == $past(strap_f.level[csd_pkg::PIN_SWING])
    ) else $error("output swing does not follow swing pin");

    edge_sel_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !ext_now && !strap_f.float_det[csd_pkg::PIN_EDGE]
        |=> !settings_reg.ddr
            && settings_reg.edge_pos == $past(strap_f.level[csd_pkg::PIN_EDGE])
    ) else $error("launch edge does not follow edge pin");

    ddr_sel_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !ext_now && strap_f.float_det[csd_pkg::PIN_EDGE]
        |=> settings_reg.ddr && !settings_reg.edge_pos
    ) else $error("floating edge pin did not give ddr clocking");

    cal_wait_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !ext_now && !strap_f.float_det[csd_pkg::PIN_DELAY]
        |=> !settings_reg.interleave
            && settings_reg.cal_long == $past(strap_f.level[csd_pkg::PIN_DELAY])
    ) else $error("calibration wait does not follow delay pin");

    strap_intlv_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !ext_now && strap_f.float_det[csd_pkg::PIN_DELAY] |=> settings_reg.interleave
    ) else $error("floating delay pin did not select interleaving");

    serial_off_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        word_evt && !ext_now |=> $stable(regs_reg) && written_mask_reg == '0
    ) else $error("serial write accepted in pin-strapped mode");

    complete_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        ext_now && written_mask_reg == csd_pkg::ALL_WRITTEN |=> config_complete_reg
    ) else $error("complete flag missing after all registers written");

    order_err_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_ok && wr_hit[2:0] == csd_pkg::SLOT_INTLV && !written_mask_reg[csd_pkg::SLOT_INTLV]
        && wr_data != csd_pkg::INTLV_RESET |=> intlv_order_err_reg
    ) else $error("bad first interleave write not flagged");

    intlv_gate_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        settings_reg.interleave && settings_reg.extended |-> $past(config_complete_reg)
    ) else $error("interleaving enabled before all first writes");

    frame_len_a: assert property (
        @(posedge serial_clk) disable iff (!reset_n || serial_select_n)
        bit_cnt_reg == csd_pkg::FRAME_LAST |=> bit_cnt_reg == 5'h00 && $changed(word_tog_reg)
    ) else $error("serial frame length wrong");

    word_hold_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        word_evt |-> $stable(word_hold_reg)
    ) else $error("serial word moved while being taken");

    reg_write_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_ok |=> written_mask_reg[$past(wr_hit[2:0])]
                  && regs_reg[$past(wr_hit[2:0])] == $past(wr_data)
    ) else $error("accepted serial write did not land");

    // leaving extended mode restarts the first-write sequence
    mode_exit_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !ext_now |=> written_mask_reg == '0 && !config_complete_reg
    ) else $error("first-write tracking kept in pin-strapped mode");

    err_sticky_a: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        intlv_order_err_reg && ext_now |=> intlv_order_err_reg
    ) else $error("order error flag dropped in extended mode");

    ext_seen_c: cover property (
        @(posedge clk_sys) disable iff (!reset_n) $rose(settings_reg.extended)
    );

    ddr_seen_c: cover property (
        @(posedge clk_sys) disable iff (!reset_n) !settings_reg.extended && settings_reg.ddr
    );

    word_seen_c: cover property (
        @(posedge clk_sys) disable iff (!reset_n) wr_ok
    );

    complete_seen_c: cover property (
        @(posedge clk_sys) disable iff (!reset_n) $rose(config_complete_reg)
    );

    b2b_frame_c: cover property (
        @(posedge serial_clk) disable iff (!reset_n || serial_select_n)
        bit_cnt_reg == csd_pkg::FRAME_LAST ##1 bit_cnt_reg == 5'h00
    );

endmodule : csd_strap_decoder

// file: csd_board_model.sv
// board controller model driving the strap pins and the serial lines
`timescale 1ns/1ns
module csd_board_model (
    output csd_pkg::csd_strap_t strap_pins,
    output logic                serial_clk,
    output logic                serial_shift_data,
    output logic                serial_select_n
);
    initial begin
        strap_pins        = '0;
        serial_clk        = 1'b0;
        serial_shift_data = 1'b0;
        serial_select_n   = 1'b1;
    end

    // a floating pin reads as the inverse of its last level, never a clean value
    task automatic set_straps(input logic [3:0] lvl, input logic [3:0] flt);
        strap_pins.level     = (lvl & ~flt) | (~strap_pins.level & flt);
        strap_pins.float_det = flt;
    endtask : set_straps

    // clock still outside frames; n below 20 aborts, above 20 repeats the word back to back
    task automatic send_frame(input logic [3:0] a, input logic [15:0] d, input int n);
        logic [19:0] w;
        w = {a, d};
        #23 serial_select_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_shift_data = w[19 - (i % 20)];
            #80 serial_clk = 1'b1;
            #80 serial_clk = 1'b0;
        end
        #40 serial_select_n = 1'b1;
        serial_shift_data = ~serial_shift_data;
    endtask : send_frame
endmodule : csd_board_model

// file: control_mode_strap_decoder_tb.sv
// self-checking bench for the strap decoder and its serial register path
`timescale 1ns/1ns
module control_mode_strap_decoder_tb;
    logic                   clk_sys;
    logic                   reset_n;
    csd_pkg::csd_strap_t    strap_pins;
    logic                   serial_clk;
    logic                   serial_shift_data;
    logic                   serial_select_n;
    csd_pkg::csd_settings_t settings_reg;
    logic [7:0]             written_mask_reg;
    logic                   config_complete_reg;
    logic                   intlv_order_err_reg;
    int                     err_count;
    int                     n_compared;
    logic [7:0]             exp_mask;
    logic [15:0]            cfg_word;
    logic [15:0]            word;
    logic [3:0]             lv;
    int                     off;

    csd_board_model csd_board_model_i (
        .strap_pins        (strap_pins),
        .serial_clk        (serial_clk),
        .serial_shift_data (serial_shift_data),
        .serial_select_n   (serial_select_n)
    );

    csd_strap_decoder csd_strap_decoder_i (
        .clk_sys             (clk_sys),
        .reset_n             (reset_n),
        .strap_pins          (strap_pins),
        .serial_clk          (serial_clk),
        .serial_shift_data   (serial_shift_data),
        .serial_select_n     (serial_select_n),
        .settings_reg        (settings_reg),
        .written_mask_reg    (written_mask_reg),
        .config_complete_reg (config_complete_reg),
        .intlv_order_err_reg (intlv_order_err_reg)
    );

    initial clk_sys = 1'b0;
    always #10 clk_sys = ~clk_sys;

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out

    task automatic chk_set(input csd_pkg::csd_settings_t got, input csd_pkg::csd_settings_t exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t settings %b expected %b", $time, got, exp);
        end
    endtask : chk_set

    task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t %s %h expected %h", $time, what, got, exp);
        end
    endtask : chk_vec

    function automatic csd_pkg::csd_settings_t exp_strap(input logic [3:0] l, input logic [3:0] f);
        csd_pkg::csd_settings_t s;
        s                  = csd_pkg::SETTINGS_RESET;
        s.swing_normal     = l[csd_pkg::PIN_SWING];
        s.ddr              = f[csd_pkg::PIN_EDGE];
        s.edge_pos         = l[csd_pkg::PIN_EDGE] & ~f[csd_pkg::PIN_EDGE];
        s.interleave       = f[csd_pkg::PIN_DELAY];
        s.cal_long         = l[csd_pkg::PIN_DELAY] & ~f[csd_pkg::PIN_DELAY];
        s.fullscale_normal = l[csd_pkg::PIN_MODE];
        return s;
    endfunction : exp_strap

    function automatic csd_pkg::csd_settings_t exp_ext(input logic [15:0] d, input logic il);
        csd_pkg::csd_settings_t s;
        s                  = csd_pkg::SETTINGS_RESET;
        s.extended         = 1'b1;
        s.swing_normal     = d[csd_pkg::CFG_SWING_BIT];
        s.ddr              = d[csd_pkg::CFG_DDR_BIT];
        s.edge_pos         = d[csd_pkg::CFG_EDGE_BIT] & ~d[csd_pkg::CFG_DDR_BIT];
        s.cal_long         = d[csd_pkg::CFG_CAL_BIT];
        s.fullscale_normal = d[csd_pkg::CFG_FS_BIT];
        s.interleave       = il;
        return s;
    endfunction : exp_ext

    // settings follow a strap change after 5 edges; one spare edge before looking
    task automatic straps(input logic [3:0] l, input logic [3:0] f);
        @(posedge clk_sys);
        #2;
        csd_board_model_i.set_straps(l, f);
        repeat (6) @(posedge clk_sys);
        #2;
    endtask : straps

    task automatic frame(input logic [3:0] a, input logic [15:0] d, input int n);
        csd_board_model_i.send_frame(a, d, n);
        repeat (12) @(posedge clk_sys);
        #2;
    endtask : frame

    initial begin
        #400000;
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end

    initial begin
        err_count  = 0;
        n_compared = 0;
        reset_n    = 1'b0;
        void'($urandom(61));
        repeat (3) @(posedge clk_sys);
        #2;
        chk_set(settings_reg, csd_pkg::SETTINGS_RESET);
        reset_n = 1'b1;
        for (int m = 0; m < 2; m++)
            for (int e = 0; e < 3; e++)
                for (int d = 0; d < 3; d++) begin
                    lv = {m[0], d == 1, e == 1, 1'($urandom)};
                    straps(lv, {1'b0, d == 2, e == 2, 1'b0});
                    chk_set(settings_reg, exp_strap(lv, {1'b0, d == 2, e == 2, 1'b0}));
                end
        for (int k = 0; k < 10; k++) begin
            lv = 4'($urandom);
            off = $urandom_range(3);
            straps(lv, {1'b0, off[1:0], 1'b0});
            chk_set(settings_reg, exp_strap(lv, {1'b0, off[1:0], 1'b0}));
        end
        // the mode pin is driven, so a frame must be dropped
        frame(4'h1, 16'hFFFF, 20);
        chk_vec(written_mask_reg, 8'h00, "strap mask");
        chk_set(settings_reg, exp_strap(lv, {1'b0, off[1:0], 1'b0}));
        $display("strap mode tests done");

        straps(4'h0, 4'h8);
        chk_set(settings_reg, exp_ext(16'h0000, 1'b0));
        frame(4'hD, csd_pkg::INTLV_RESET, 20);
        exp_mask = 8'h40;
        frame(4'h0, 16'hFFFF, 20);
        frame(4'h1, 16'hFFFF, 10);
        chk_vec(written_mask_reg, exp_mask, "mask");
        off = $urandom_range(7);
        cfg_word = 16'($urandom);
        for (int k = 0; k < 8; k++) begin
            if ((k + off) % 8 != csd_pkg::SLOT_INTLV) begin
                word = ((k + off) % 8 == 0) ? cfg_word : 16'($urandom);
                frame(csd_pkg::SLOT_ADDR[(k + off) % 8], word, 20 + 10 * (k % 2));
                exp_mask[(k + off) % 8] = 1'b1;
                chk_vec(written_mask_reg, exp_mask, "mask");
                chk_vec({7'h00, config_complete_reg}, {7'h00, exp_mask == 8'hFF}, "done");
            end
        end
        chk_vec({7'h00, intlv_order_err_reg}, 8'h00, "order");
        chk_set(settings_reg, exp_ext(cfg_word, 1'b0));
        frame(4'hD, 16'h8000 | 16'($urandom), 20);
        chk_set(settings_reg, exp_ext(cfg_word, 1'b1));
        $display("extended mode tests done");

        straps(4'h0, 4'h0);
        chk_vec(written_mask_reg, 8'h00, "leave mask");
        straps(4'h0, 4'h8);
        frame(4'hD, 16'hBFFF, 20);
        chk_vec({7'h00, intlv_order_err_reg}, 8'h01, "order");
        chk_vec(written_mask_reg, 8'h40, "mask");
        chk_set(settings_reg, exp_ext(cfg_word, 1'b0));
        $display("order error tests done");
        close_out();
    end
endmodule : control_mode_strap_decoder_tb
